// ==== verilog/dim_pkg.sv ====
// Package for the converter interrupt enable block: offsets, field positions, reset values.
// Assumes a 32-bit register port with byte addresses and one clock.
package dim_pkg;

  // Register byte offsets.
  localparam logic [11:0] DIM_EVT_EN_OFS   = 12'h36C;  // Event enable register.
  localparam logic [11:0] DIM_ERR_EN_OFS   = 12'h370;  // Error enable register.
  localparam logic [11:0] DIM_EVT_STAT_OFS = 12'h384;  // Event status, read clears.
  localparam logic [11:0] DIM_ERR_STAT_OFS = 12'h388;  // Error status, read clears.

  // Event enable field positions.
  localparam int DIM_FTIM_BIT     = 29;  // Frame timer.
  localparam int DIM_FTRIG_BIT    = 28;  // Frame trigger.
  localparam int DIM_CONV_LSB     = 16;  // Converter one update, three follow.
  localparam int DIM_SEQ_DONE_BIT = 4;   // Sequencer frames complete.
  localparam int DIM_SEQ_BUF_BIT  = 0;   // Sequencer buffer complete.

  // Error enable field positions.
  localparam int DIM_FRAME_F_BIT  = 19;  // Sequencer frame fault.
  localparam int DIM_TIME_F_BIT   = 18;  // Sequencer timing fault.
  localparam int DIM_DATA_F_BIT   = 17;  // Sequencer data fault.
  localparam int DIM_XFER_F_BIT   = 16;  // Sequencer transfer fault.
  localparam int DIM_CONV_F_LSB   = 0;   // Converter one fault, three follow.

  // Writable bits of each register; all others read as zero.
  localparam logic [31:0] DIM_EVT_MASK = 32'h300F_0011;
  localparam logic [31:0] DIM_ERR_MASK = 32'h000F_000F;

  // Reset values.
  localparam logic [31:0] DIM_EN_RST   = 32'h0000_0000;
  localparam logic [31:0] DIM_STAT_RST = 32'h0000_0000;

endpackage : dim_pkg

// ==== verilog/dim_sticky_reg.sv ====
// Holds one 32-bit group of enable bits and the matching sticky status bits.
// Assumes events are single-clock pulses on clk and that rst is synchronous.
`timescale 1ns/1ps
`default_nettype none
module dim_sticky_reg
  import dim_pkg::*;
#(
  parameter logic [31:0] MASK = 32'hFFFF_FFFF
)(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        en_wr,
  input  wire logic [31:0] wdata,
  input  wire logic        stat_clr,
  input  wire logic [31:0] events,
  output logic      [31:0] en_q,
  output logic      [31:0] stat_q
);

  // Enable register; written bits outside the mask are dropped.
  always_ff @(posedge clk)
  begin
    if (rst)
      en_q <= DIM_EN_RST;
    else if (en_wr)
      en_q <= wdata & MASK;
  end

  // Status bits latch only when the enable already stood before the event.
  // A new event beats a clear in the same cycle.
  always_ff @(posedge clk)
  begin
    if (rst)
      stat_q <= DIM_STAT_RST;
    else
      stat_q <= ((stat_clr ? 32'h0000_0000 : stat_q) | (events & en_q)) & MASK;
  end

  // An event while its enable is clear, outside a clearing read, leaves the status bit as it was.
  a_blocked_event: assert property (@(posedge clk) disable iff (rst)
    (!stat_clr && (events & ~en_q) != 32'h0000_0000) |=>
      ((stat_q & ~$past(stat_q) & ~$past(en_q)) == 32'h0000_0000))
    else $error("Disabled event was recorded.");

  // An enabled event is always recorded on the next edge.
  a_enabled_event: assert property (@(posedge clk) disable iff (rst)
    ((events & en_q & MASK) != 32'h0000_0000) |=>
      ((stat_q & $past(events) & $past(en_q) & MASK) == ($past(events) & $past(en_q) & MASK)))
    else $error("Enabled event was lost.");

  // Reserved bits never appear.
  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    ((en_q | stat_q) & ~MASK) == 32'h0000_0000)
    else $error("Reserved bit became set.");

endmodule : dim_sticky_reg
`default_nettype wire

// ==== verilog/dim_irq_enable.sv ====
// Interrupt enable and status registers for the converter board's event and error sources.
// Assumes a single-clock register port, read data one cycle after the read strobe.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module dim_irq_enable
  import dim_pkg::*;
#(
  parameter int NUM_CONV = 4  // Number of converter devices.
)(
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [11:0]         addr,
  input  wire logic [31:0]         wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  output logic      [31:0]         rdata,
  output logic                     irq,
  input  wire logic                frame_timer_evt,
  input  wire logic                frame_trigger_evt,
  input  wire logic [NUM_CONV-1:0] converter_update_evt,
  input  wire logic                sequencer_frames_complete_evt,
  input  wire logic                sequencer_buffer_complete_evt,
  input  wire logic                sequencer_frame_fault_evt,
  input  wire logic                sequencer_timing_fault_evt,
  input  wire logic                sequencer_data_fault_evt,
  input  wire logic                sequencer_transfer_fault_evt,
  input  wire logic [NUM_CONV-1:0] converter_fault_evt
);

  // Register map: the event enable and error enable words are read/write,
  // each with its own sticky status word that a read clears. Any other
  // address reads as zero and swallows writes. Enable bits gate events
  // before they reach status, so a status bit never needs a second mask
  // on its way to the interrupt; clearing an enable keeps what is latched.

  // Register views of both groups.
  logic [31:0] evt_en;    // Event enable register.
  logic [31:0] err_en;    // Error enable register.
  logic [31:0] evt_stat;  // Event status bits.
  logic [31:0] err_stat;  // Error status bits.
  logic [31:0] evt_vec;   // Event pulses placed at their enable positions.
  logic [31:0] err_vec;   // Fault pulses placed at their enable positions.
  logic        evt_clr;   // Read of event status clears it.
  logic        err_clr;   // Read of error status clears it.

  // Place each event at the bit of its enable.
  always_comb
  begin
    evt_vec = 32'h0000_0000;
    evt_vec[DIM_FTIM_BIT]     = frame_timer_evt;
    evt_vec[DIM_FTRIG_BIT]    = frame_trigger_evt;
    evt_vec[DIM_CONV_LSB +: NUM_CONV] = converter_update_evt;
    evt_vec[DIM_SEQ_DONE_BIT] = sequencer_frames_complete_evt;
    evt_vec[DIM_SEQ_BUF_BIT]  = sequencer_buffer_complete_evt;
  end

  // Place each fault at the bit of its enable.
  always_comb
  begin
    err_vec = 32'h0000_0000;
    err_vec[DIM_FRAME_F_BIT] = sequencer_frame_fault_evt;
    err_vec[DIM_TIME_F_BIT]  = sequencer_timing_fault_evt;
    err_vec[DIM_DATA_F_BIT]  = sequencer_data_fault_evt;
    err_vec[DIM_XFER_F_BIT]  = sequencer_transfer_fault_evt;
    err_vec[DIM_CONV_F_LSB +: NUM_CONV] = converter_fault_evt;
  end

  // Reads of a status register clear it as the data are returned.
  assign evt_clr = rd && (addr == DIM_EVT_STAT_OFS);
  assign err_clr = rd && (addr == DIM_ERR_STAT_OFS);

  // Event group: enables and sticky status.
  dim_sticky_reg #(
    .MASK (DIM_EVT_MASK)
  ) u_evt (
    .clk      (clk),
    .rst      (rst),
    .en_wr    (wr && (addr == DIM_EVT_EN_OFS)),
    .wdata    (wdata),
    .stat_clr (evt_clr),
    .events   (evt_vec),
    .en_q     (evt_en),
    .stat_q   (evt_stat)
  );

  // Error group: enables and sticky status.
  dim_sticky_reg #(
    .MASK (DIM_ERR_MASK)
  ) u_err (
    .clk      (clk),
    .rst      (rst),
    .en_wr    (wr && (addr == DIM_ERR_EN_OFS)),
    .wdata    (wdata),
    .stat_clr (err_clr),
    .events   (err_vec),
    .en_q     (err_en),
    .stat_q   (err_stat)
  );

  // Read data register; unmapped addresses and idle cycles return zero.
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata <= 32'h0000_0000;
    else if (rd)
    begin
      unique case (addr)
        DIM_EVT_EN_OFS:   rdata <= evt_en;
        DIM_ERR_EN_OFS:   rdata <= err_en;
        DIM_EVT_STAT_OFS: rdata <= evt_stat;
        DIM_ERR_STAT_OFS: rdata <= err_stat;
        default:          rdata <= 32'h0000_0000;
      endcase
    end
    else
      rdata <= 32'h0000_0000;
  end

  // Interrupt follows any set status bit, registered.
  always_ff @(posedge clk)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= (evt_stat | err_stat) != 32'h0000_0000;
  end

  // A write strobe aimed at the event enable register.
  sequence s_evt_write;
    wr && (addr == DIM_EVT_EN_OFS);
  endsequence

  // A read strobe of the event enable register with no write beside it.
  sequence s_evt_read;
    rd && (addr == DIM_EVT_EN_OFS) && !wr;
  endsequence

  // A write strobe aimed at the error enable register.
  sequence s_err_write;
    wr && (addr == DIM_ERR_EN_OFS);
  endsequence

  // A read strobe of the error enable register with no write beside it.
  sequence s_err_read;
    rd && (addr == DIM_ERR_EN_OFS) && !wr;
  endsequence

  // Write then read of the event enable returns the masked value.
  a_evt_readback: assert property (@(posedge clk) disable iff (rst)
    s_evt_write ##1 s_evt_read |=> rdata == ($past(wdata, 2) & DIM_EVT_MASK))
    else $error("Event enable readback wrong.");

  // Error enable readback, spanning the same two steps.
  a_err_readback: assert property (@(posedge clk) disable iff (rst)
    s_err_write ##1 s_err_read |=> rdata == ($past(wdata, 2) & DIM_ERR_MASK))
    else $error("Error enable readback wrong.");

  // Enabled frame timer event raises the interrupt two edges later.
  a_ftim_irq: assert property (@(posedge clk) disable iff (rst)
    (frame_timer_evt && evt_en[DIM_FTIM_BIT]) |=> ##1 irq)
    else $error("Frame timer event did not interrupt.");

  // A frame timer event while its enable is clear leaves no mark.
  a_ftim_blocked: assert property (@(posedge clk) disable iff (rst)
    (frame_timer_evt && !evt_en[DIM_FTIM_BIT] && !evt_stat[DIM_FTIM_BIT]) |=>
      !evt_stat[DIM_FTIM_BIT])
    else $error("Blocked frame timer event was recorded.");

  // Enabled frame trigger event is recorded on the next edge.
  a_ftrig_record: assert property (@(posedge clk) disable iff (rst)
    (frame_trigger_evt && evt_en[DIM_FTRIG_BIT]) |=> evt_stat[DIM_FTRIG_BIT])
    else $error("Frame trigger event not recorded.");

  // A frame trigger event while its enable is clear leaves no mark.
  a_ftrig_blocked: assert property (@(posedge clk) disable iff (rst)
    (frame_trigger_evt && !evt_en[DIM_FTRIG_BIT] && !evt_stat[DIM_FTRIG_BIT]) |=>
      !evt_stat[DIM_FTRIG_BIT])
    else $error("Blocked frame trigger event was recorded.");

  // Every enabled converter update is recorded on the next edge.
  a_conv_record: assert property (@(posedge clk) disable iff (rst)
    ((converter_update_evt & evt_en[DIM_CONV_LSB +: NUM_CONV]) != '0) |=>
      ((evt_stat[DIM_CONV_LSB +: NUM_CONV] &
        $past(converter_update_evt & evt_en[DIM_CONV_LSB +: NUM_CONV])) ==
       $past(converter_update_evt & evt_en[DIM_CONV_LSB +: NUM_CONV])))
    else $error("Converter update event not recorded.");

  // Converter updates whose enables are clear set nothing new.
  a_conv_blocked: assert property (@(posedge clk) disable iff (rst)
    ((converter_update_evt & ~evt_en[DIM_CONV_LSB +: NUM_CONV]) != '0) |=>
      ((evt_stat[DIM_CONV_LSB +: NUM_CONV] &
        $past(converter_update_evt & ~evt_en[DIM_CONV_LSB +: NUM_CONV] &
              ~evt_stat[DIM_CONV_LSB +: NUM_CONV])) == '0))
    else $error("Blocked converter update was recorded.");

  // Enabled sequencer frames complete event is recorded.
  a_frames_record: assert property (@(posedge clk) disable iff (rst)
    (sequencer_frames_complete_evt && evt_en[DIM_SEQ_DONE_BIT]) |=> evt_stat[DIM_SEQ_DONE_BIT])
    else $error("Frames complete event not recorded.");

  // A frames complete event while its enable is clear leaves no mark.
  a_frames_blocked: assert property (@(posedge clk) disable iff (rst)
    (sequencer_frames_complete_evt && !evt_en[DIM_SEQ_DONE_BIT] &&
     !evt_stat[DIM_SEQ_DONE_BIT]) |=> !evt_stat[DIM_SEQ_DONE_BIT])
    else $error("Blocked frames complete event was recorded.");

  // Enabled sequencer buffer complete event is recorded.
  a_buffer_record: assert property (@(posedge clk) disable iff (rst)
    (sequencer_buffer_complete_evt && evt_en[DIM_SEQ_BUF_BIT]) |=> evt_stat[DIM_SEQ_BUF_BIT])
    else $error("Buffer complete event not recorded.");

  // A buffer complete event while its enable is clear leaves no mark.
  a_buffer_blocked: assert property (@(posedge clk) disable iff (rst)
    (sequencer_buffer_complete_evt && !evt_en[DIM_SEQ_BUF_BIT] &&
     !evt_stat[DIM_SEQ_BUF_BIT]) |=> !evt_stat[DIM_SEQ_BUF_BIT])
    else $error("Blocked buffer complete event was recorded.");

  // Enabled frame fault is recorded.
  a_frame_fault: assert property (@(posedge clk) disable iff (rst)
    (sequencer_frame_fault_evt && err_en[DIM_FRAME_F_BIT]) |=> err_stat[DIM_FRAME_F_BIT])
    else $error("Frame fault not recorded.");

  // Enabled timing fault is recorded.
  a_timing_fault: assert property (@(posedge clk) disable iff (rst)
    (sequencer_timing_fault_evt && err_en[DIM_TIME_F_BIT]) |=> err_stat[DIM_TIME_F_BIT])
    else $error("Timing fault not recorded.");

  // Enabled data fault is recorded.
  a_data_fault: assert property (@(posedge clk) disable iff (rst)
    (sequencer_data_fault_evt && err_en[DIM_DATA_F_BIT]) |=> err_stat[DIM_DATA_F_BIT])
    else $error("Data fault not recorded.");

  // Enabled transfer fault is recorded.
  a_xfer_fault: assert property (@(posedge clk) disable iff (rst)
    (sequencer_transfer_fault_evt && err_en[DIM_XFER_F_BIT]) |=> err_stat[DIM_XFER_F_BIT])
    else $error("Transfer fault not recorded.");

  // Sequencer faults whose enables are clear set nothing new.
  a_seq_fault_blocked: assert property (@(posedge clk) disable iff (rst)
    ((err_vec[DIM_XFER_F_BIT +: 4] & ~err_en[DIM_XFER_F_BIT +: 4]) != 4'h0) |=>
      ((err_stat[DIM_XFER_F_BIT +: 4] &
        $past(err_vec[DIM_XFER_F_BIT +: 4] & ~err_en[DIM_XFER_F_BIT +: 4] &
              ~err_stat[DIM_XFER_F_BIT +: 4])) == 4'h0))
    else $error("Blocked sequencer fault was recorded.");

  // Every enabled converter fault is recorded on the next edge.
  a_conv_fault_record: assert property (@(posedge clk) disable iff (rst)
    ((converter_fault_evt & err_en[DIM_CONV_F_LSB +: NUM_CONV]) != '0) |=>
      ((err_stat[DIM_CONV_F_LSB +: NUM_CONV] &
        $past(converter_fault_evt & err_en[DIM_CONV_F_LSB +: NUM_CONV])) ==
       $past(converter_fault_evt & err_en[DIM_CONV_F_LSB +: NUM_CONV])))
    else $error("Converter fault not recorded.");

  // Converter faults whose enables are clear set nothing new.
  a_conv_fault_blocked: assert property (@(posedge clk) disable iff (rst)
    ((converter_fault_evt & ~err_en[DIM_CONV_F_LSB +: NUM_CONV]) != '0) |=>
      ((err_stat[DIM_CONV_F_LSB +: NUM_CONV] &
        $past(converter_fault_evt & ~err_en[DIM_CONV_F_LSB +: NUM_CONV] &
              ~err_stat[DIM_CONV_F_LSB +: NUM_CONV])) == '0))
    else $error("Blocked converter fault was recorded.");

  // Interrupt tracks status with one cycle of delay.
  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    irq == $past((evt_stat | err_stat) != 32'h0000_0000))
    else $error("Interrupt does not follow status.");

  // With all enables clear and status empty the interrupt stays low.
  a_irq_quiet: assert property (@(posedge clk) disable iff (rst)
    (evt_en == 32'h0000_0000 && err_en == 32'h0000_0000 &&
     evt_stat == 32'h0000_0000 && err_stat == 32'h0000_0000) |=> ##1 !irq)
    else $error("Interrupt rose with everything disabled.");

  // A status read with no new event returns zero next time.
  a_stat_clear: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == DIM_EVT_STAT_OFS && evt_vec == 32'h0000_0000) |=> evt_stat == 32'h0000_0000)
    else $error("Status read did not clear.");

  // An error status read with no new fault empties the error status.
  a_err_stat_clear: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == DIM_ERR_STAT_OFS && err_vec == 32'h0000_0000) |=> err_stat == 32'h0000_0000)
    else $error("Error status read did not clear.");

  // Read data stand only in the cycle after a read strobe.
  a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
    !rd |=> (rdata == 32'h0000_0000))
    else $error("Read data not zero outside a read.");

endmodule : dim_irq_enable
`default_nettype wire

// ==== bench/dim_irq_enable_test.sv ====
// Self-checking bench for the event and error interrupt enable registers.
// Assumes the design answers reads one cycle after the strobe and has a 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fails++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module dim_irq_enable_test;
  import dim_pkg::*;
  logic        clk = 1'b0;        // Bench clock.
  logic        rst = 1'b1;        // Synchronous reset.
  logic [11:0] addr = 12'h000;    // Register address.
  logic [31:0] wdata = 32'h0;     // Write data.
  logic        wr = 1'b0;         // Write strobe.
  logic        rd = 1'b0;         // Read strobe.
  logic [31:0] rdata;             // Read data from the design.
  logic        irq;               // Interrupt from the design.
  logic [31:0] ev = 32'h0;        // Event pulses laid out as the event register.
  logic [31:0] er = 32'h0;        // Fault pulses laid out as the error register.
  int          fails = 0;         // Mismatch count.
  int          compares = 0;      // Comparison count.
  // Rows: address, value written, value expected back.
  logic [11:0] r_a [5] = '{DIM_EVT_EN_OFS, DIM_ERR_EN_OFS, DIM_EVT_EN_OFS, DIM_ERR_EN_OFS, 12'h374};
  logic [31:0] r_w [5] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hA5A5_A5A5, 32'h5A5A_5A5A, 32'hFFFF_FFFF};
  logic [31:0] r_e [5] = '{32'h300F_0011, 32'h000F_000F, 32'h2005_0001, 32'h000A_000A, 32'h0};

  // The clock toggles every half period of 10 ns.
  always #10 clk = ~clk;

  dim_irq_enable dut_u (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq),
    .frame_timer_evt(ev[29]), .frame_trigger_evt(ev[28]),
    .converter_update_evt(ev[19:16]),
    .sequencer_frames_complete_evt(ev[4]), .sequencer_buffer_complete_evt(ev[0]),
    .sequencer_frame_fault_evt(er[19]), .sequencer_timing_fault_evt(er[18]),
    .sequencer_data_fault_evt(er[17]), .sequencer_transfer_fault_evt(er[16]),
    .converter_fault_evt(er[3:0])
  );

  // One-cycle register write.
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // One-cycle read; the data is checked in the cycle after the strobe.
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask

  // One-cycle pulse on chosen event and fault inputs.
  task automatic pulse(input logic [31:0] e, input logic [31:0] f);
    @(posedge clk);
    ev <= e; er <= f;
    @(posedge clk);
    ev <= 32'h0; er <= 32'h0;
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic tally_and_finish;
    $display("Comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence: reset, table of accesses, per-source gating, corner cases.
  initial
  begin
    logic [31:0] b;
    logic        is_err;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rd_chk(DIM_EVT_EN_OFS, 32'h0);
    rd_chk(DIM_ERR_EN_OFS, 32'h0);
    `CHK("irq", 1'b0, irq)
    $display("Test reset values done");
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(r_a[i], r_w[i]);
      rd_chk(r_a[i], r_e[i]);
    end
    $display("Test register rows done");
    // Write and read with no idle cycle between the strobes.
    @(posedge clk);
    wr <= 1'b1; addr <= DIM_EVT_EN_OFS; wdata <= 32'hFFFF_FFFF;
    @(posedge clk);
    wr <= 1'b0; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", 32'h300F_0011, rdata)
    @(posedge clk);
    wr <= 1'b1; addr <= DIM_ERR_EN_OFS; wdata <= 32'h5A5A_5A5A;
    @(posedge clk);
    wr <= 1'b0; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK("rdata", 32'h000A_000A, rdata)
    $display("Test back-to-back access done");
    // Each source alone: lost while disabled, recorded and raising irq while enabled.
    for (int i = 0; i < 64; i++)
    begin
      is_err = (i >= 32);
      b = 32'h1 << (i % 32);
      if ((b & (is_err ? DIM_ERR_MASK : DIM_EVT_MASK)) != 32'h0)
      begin
        wr_reg(DIM_EVT_EN_OFS, 32'h0);
        wr_reg(DIM_ERR_EN_OFS, 32'h0);
        pulse(is_err ? 32'h0 : b, is_err ? b : 32'h0);
        rd_chk(is_err ? DIM_ERR_STAT_OFS : DIM_EVT_STAT_OFS, 32'h0);
        wr_reg(is_err ? DIM_ERR_EN_OFS : DIM_EVT_EN_OFS, b);
        pulse(is_err ? 32'h0 : b, is_err ? b : 32'h0);
        repeat (2) @(posedge clk);
        #1;
        `CHK("irq", 1'b1, irq)
        rd_chk(is_err ? DIM_ERR_STAT_OFS : DIM_EVT_STAT_OFS, b);
        rd_chk(is_err ? DIM_ERR_STAT_OFS : DIM_EVT_STAT_OFS, 32'h0);
        `CHK("irq", 1'b0, irq)
      end
    end
    $display("Test source gating done");
    // Enable written at the same edge as the event must not let it through.
    wr_reg(DIM_EVT_EN_OFS, 32'h0);
    @(posedge clk);
    wr <= 1'b1; addr <= DIM_EVT_EN_OFS; wdata <= 32'h1; ev <= 32'h1;
    @(posedge clk);
    wr <= 1'b0; ev <= 32'h0;
    rd_chk(DIM_EVT_STAT_OFS, 32'h0);
    // An event in the same cycle as the clearing read is kept.
    pulse(32'h1, 32'h0);
    @(posedge clk);
    rd <= 1'b1; addr <= DIM_EVT_STAT_OFS; ev <= 32'h1;
    @(posedge clk);
    rd <= 1'b0; ev <= 32'h0;
    #1;
    `CHK("rdata", 32'h1, rdata)
    rd_chk(DIM_EVT_STAT_OFS, 32'h1);
    $display("Test same-edge cases done");
    // A second reset in mid-run clears enables, status and irq.
    wr_reg(DIM_ERR_EN_OFS, 32'h8);
    pulse(32'h0, 32'h8);
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq", 1'b1, irq)
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK("irq", 1'b0, irq)
    rd_chk(DIM_ERR_EN_OFS, 32'h0);
    rd_chk(DIM_ERR_STAT_OFS, 32'h0);
    $display("Test mid-run reset done");
    tally_and_finish();
  end
endmodule // dim_irq_enable_test
`default_nettype wire
